// File: src/pwmem_top.sv
// four-channel pwm mode switch, edge builder, output combiner and sync rectifier
// How it works
// - with auto switching on, filter duty picks base, mid or high set
// - four thresholds in two upper/lower pairs give hysteresis
// - base to mid above low-upper, back below low-lower only
// - aux wave spans blank begin to blank end of each channel
// - edge builder uses own and next channel, three wraps to zero
// - each of four output edges picks one of eight sources
// - codes 0-3 own a/b rise/fall, 4-7 the same of next
// - combiner selects live in the three config sets
// - a combiner codes 0 to 8 as listed
// - b combiner codes 0 to 8 as listed
// - neighbour indices for the combiner wrap modulo four
// - combiner off: a and b come straight from normal generation
// - current trip during a conduction ends the a pulse at once
// - optionally the b pulse matches the truncated a width
// - rectifier held off until nominal, then ramped slowly on
// - diode emulation on-time from firmware vin, vout and filter duty
`timescale 1ns/100ps
`default_nettype none
module pwmem_top #(
  parameter int NCH = pwmem_pkg::NCH_DEF,
  parameter int TW  = pwmem_pkg::TW_DEF
) (
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  input  wire logic [pwmem_pkg::AW-1:0] reg_addr,
  input  wire logic [pwmem_pkg::DW-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [pwmem_pkg::DW-1:0]      reg_rdata,
  input  wire logic [NCH-1:0][TW-1:0]   filter_duty,
  input  wire logic [NCH-1:0]           cl_trip,
  input  wire logic                     out_nominal,
  output logic [NCH-1:0]                pwm_out_a,
  output logic [NCH-1:0]                pwm_out_b,
  output logic [NCH-1:0]                sr_drive
);
  import pwmem_pkg::*;

  // ****************************************
  // elaboration check
  // ****************************************
  if (NCH < 4 || TW < 8 || TW > 16) begin : g_chk
    $error("pwmem_top: NCH must be >= 4 and TW within 8..16");
  end

  pwmem_req_t    req;
  logic [2:0]    ctrl_ff;
  logic [TW-1:0] period_ff;
  logic [TW-1:0] lo_up_ff;
  logic [TW-1:0] lo_lo_ff;
  logic [TW-1:0] hi_up_ff;
  logic [TW-1:0] hi_lo_ff;
  pwmem_cfg_t    cfg_ff [3];
  pwmem_edge_t   edge_ff;
  logic [TW-1:0] bl_beg_ff;
  logic [TW-1:0] bl_end_ff;
  logic [TW-1:0] vin_ff;
  logic [TW-1:0] vout_ff;
  logic [DW-1:0] reg_rdata_ff;
  logic [DW-1:0] stat;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff   <= '0;
      period_ff <= TW'(PERIOD_RST);
      lo_up_ff  <= TW'(LO_UP_RST);
      lo_lo_ff  <= TW'(LO_LO_RST);
      hi_up_ff  <= TW'(HI_UP_RST);
      hi_lo_ff  <= TW'(HI_LO_RST);
      cfg_ff    <= '{default: '0};
      edge_ff   <= '0;
      bl_beg_ff <= '0;
      bl_end_ff <= '0;
      vin_ff    <= '0;
      vout_ff   <= TW'(VOUT_RST);
    end else if (req.wr) begin
      unique case (req.addr)
        REG_CTRL:   ctrl_ff   <= req.wdata[2:0];
        REG_PERIOD: period_ff <= req.wdata[TW-1:0];
        REG_LO_UP:  lo_up_ff  <= req.wdata[TW-1:0];
        REG_LO_LO:  lo_lo_ff  <= req.wdata[TW-1:0];
        REG_HI_UP:  hi_up_ff  <= req.wdata[TW-1:0];
        REG_HI_LO:  hi_lo_ff  <= req.wdata[TW-1:0];
        REG_CFG_B:  cfg_ff[0] <= req.wdata[8:0];
        REG_CFG_M:  cfg_ff[1] <= req.wdata[8:0];
        REG_CFG_H:  cfg_ff[2] <= req.wdata[8:0];
        REG_EDGE:   edge_ff   <= req.wdata[11:0];
        REG_BLANK: begin
          bl_beg_ff <= req.wdata[TW-1:0];
          bl_end_ff <= req.wdata[BLANK_END +: TW];
        end
        REG_VIN:    vin_ff    <= req.wdata[TW-1:0];
        REG_VOUT:   vout_ff   <= req.wdata[TW-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // register reads, data one cycle later
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= '0;
    end else if (req.rd) begin
      unique case (req.addr)
        REG_CTRL:   reg_rdata_ff <= DW'(ctrl_ff);
        REG_PERIOD: reg_rdata_ff <= DW'(period_ff);
        REG_LO_UP:  reg_rdata_ff <= DW'(lo_up_ff);
        REG_LO_LO:  reg_rdata_ff <= DW'(lo_lo_ff);
        REG_HI_UP:  reg_rdata_ff <= DW'(hi_up_ff);
        REG_HI_LO:  reg_rdata_ff <= DW'(hi_lo_ff);
        REG_CFG_B:  reg_rdata_ff <= DW'(cfg_ff[0]);
        REG_CFG_M:  reg_rdata_ff <= DW'(cfg_ff[1]);
        REG_CFG_H:  reg_rdata_ff <= DW'(cfg_ff[2]);
        REG_EDGE:   reg_rdata_ff <= DW'(edge_ff);
        REG_BLANK:  reg_rdata_ff <= DW'({bl_end_ff, bl_beg_ff});
        REG_VIN:    reg_rdata_ff <= DW'(vin_ff);
        REG_VOUT:   reg_rdata_ff <= DW'(vout_ff);
        REG_STAT:   reg_rdata_ff <= stat;
        default:    reg_rdata_ff <= '0;
      endcase
    end else begin
      reg_rdata_ff <= '0;
    end
  end
  assign reg_rdata = reg_rdata_ff;

  // ****************************************
  // channels
  // ****************************************
  pwmem_wave_t   w       [NCH];
  pwmem_wave_t   prev_ff [NCH];
  logic          bnd     [NCH];
  logic [TW-1:0] cnt     [NCH];
  logic [3:0]    ev      [NCH];
  pwmem_mode_t   mode_ff [NCH];
  pwmem_mode_t   nxt_mode[NCH];
  pwmem_cfg_t    act_ff  [NCH];
  pwmem_edge_t   aedge_ff[NCH];
  logic [3:0]    pick    [NCH];
  logic [NCH-1:0] eb_a_ff;
  logic [NCH-1:0] eb_b_ff;
  logic [TW-1:0]  sr_lim;

  // edge event of one source code
  function automatic logic sel_ev(input logic [2:0] code,
                                  input logic [3:0] own,
                                  input logic [3:0] nxt);
    sel_ev = code[EDGE_NEXT] ? nxt[code[1:0]] : own[code[1:0]];
  endfunction : sel_ev

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam int N1 = (c + 1) % NCH;
    localparam int N2 = (c + 2) % NCH;
    localparam int N3 = (c + 3) % NCH;
    logic [8:0] src_a;
    logic [8:0] src_b;

    pwmem_chan #(.TW(TW)) u_chan (
      .ref_clk     (ref_clk),
      .nrst        (nrst),
      .period      (period_ff),
      .duty        (filter_duty[c]),
      .blank_begin (bl_beg_ff),
      .blank_end   (bl_end_ff),
      .match_en    (ctrl_ff[CTRL_MATCH]),
      .cl_trip     (cl_trip[c]),
      .wave        (w[c]),
      .bnd         (bnd[c]),
      .cnt         (cnt[c])
    );

    // hysteresis mode choice from filter duty
    always_comb begin
      nxt_mode[c] = mode_ff[c];
      if (!ctrl_ff[CTRL_AUTO]) begin
        nxt_mode[c] = MODE_BASE;
      end else begin
        unique case (mode_ff[c])
          MODE_BASE: if (filter_duty[c] > lo_up_ff) nxt_mode[c] = MODE_MID;
          MODE_MID: begin
            if (filter_duty[c] < lo_lo_ff) nxt_mode[c] = MODE_BASE;
            else if (filter_duty[c] > hi_up_ff) nxt_mode[c] = MODE_HIGH;
          end
          MODE_HIGH: if (filter_duty[c] < hi_lo_ff) nxt_mode[c] = MODE_MID;
          default: nxt_mode[c] = MODE_BASE;
        endcase
      end
    end

    // mode, active set and edge sources move only at period end
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        mode_ff[c]  <= MODE_BASE;
        act_ff[c]   <= '0;
        aedge_ff[c] <= '0;
      end else if (bnd[c]) begin
        mode_ff[c]  <= nxt_mode[c];
        aedge_ff[c] <= edge_ff;
        unique case (nxt_mode[c])
          MODE_MID:  act_ff[c] <= cfg_ff[1];
          MODE_HIGH: act_ff[c] <= cfg_ff[2];
          default:   act_ff[c] <= cfg_ff[0];
        endcase
      end
    end

    // edge events: a rise, a fall, b rise, b fall
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        prev_ff[c] <= '0;
      end else begin
        prev_ff[c] <= w[c];
      end
    end
    assign ev[c] = {prev_ff[c].b & ~w[c].b, w[c].b & ~prev_ff[c].b,
                    prev_ff[c].a & ~w[c].a, w[c].a & ~prev_ff[c].a};

    // edge builder sources from own and next channel
    assign pick[c] = {sel_ev(aedge_ff[c].b_fall, ev[c], ev[N1]),
                      sel_ev(aedge_ff[c].b_rise, ev[c], ev[N1]),
                      sel_ev(aedge_ff[c].a_fall, ev[c], ev[N1]),
                      sel_ev(aedge_ff[c].a_rise, ev[c], ev[N1])};

    // edge-built outputs, setting edge wins
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        eb_a_ff[c] <= 1'b0;
        eb_b_ff[c] <= 1'b0;
      end else begin
        eb_a_ff[c] <= pick[c][0] | (eb_a_ff[c] & ~pick[c][1]);
        eb_b_ff[c] <= pick[c][2] | (eb_b_ff[c] & ~pick[c][3]);
      end
    end

    // combiner candidates indexed by select code
    assign src_a = {w[N3].aux, w[N2].aux, w[N1].aux, w[N1].b, w[N1].a,
                    w[c].b, w[c].aux, eb_a_ff[c], w[c].a};
    assign src_b = {w[N3].aux, w[N2].aux, w[N1].aux, w[N1].b, w[N1].a,
                    w[c].a, w[c].aux, eb_b_ff[c], w[c].b};

    // registered outputs
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        pwm_out_a[c] <= 1'b0;
        pwm_out_b[c] <= 1'b0;
        sr_drive[c]  <= 1'b0;
      end else begin
        if (act_ff[c].comb_en && act_ff[c].sel_a <= CMB_AUX3) begin
          pwm_out_a[c] <= src_a[act_ff[c].sel_a];
        end else begin
          pwm_out_a[c] <= w[c].a;
        end
        if (act_ff[c].comb_en && act_ff[c].sel_b <= CMB_AUX3) begin
          pwm_out_b[c] <= src_b[act_ff[c].sel_b];
        end else begin
          pwm_out_b[c] <= w[c].b;
        end
        sr_drive[c] <= ctrl_ff[CTRL_SR] && out_nominal && (cnt[c] < sr_lim);
      end
    end
  end

  // ****************************************
  // sync rectifier ramp and diode emulation
  // ****************************************
  logic [TW-1:0]   ramp_ff;
  logic [7:0]      rdiv_ff;
  logic [TW-1:0]   ide_ff;
  logic [TW-1:0]   vdiff;
  logic [2*TW-1:0] prod;

  assign vdiff  = (vin_ff > vout_ff) ? vin_ff - vout_ff : '0;
  assign prod   = filter_duty[0] * vdiff;
  assign sr_lim = (ramp_ff < ide_ff) ? ramp_ff : ide_ff;

  // on-time from firmware voltages and filter duty
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ide_ff <= '0;
    end else begin
      ide_ff <= TW'(prod >> IDE_SHIFT);
    end
  end

  // ramp one step every RAMP_PER periods once nominal
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ramp_ff <= '0;
      rdiv_ff <= '0;
    end else if (!out_nominal || !ctrl_ff[CTRL_SR]) begin
      ramp_ff <= '0;
      rdiv_ff <= '0;
    end else if (bnd[0]) begin
      if (rdiv_ff == 8'(RAMP_PER - 1)) begin
        rdiv_ff <= '0;
        if (ramp_ff < period_ff) ramp_ff <= ramp_ff + TW'(1);
      end else begin
        rdiv_ff <= rdiv_ff + 8'h01;
      end
    end
  end

  // status word: two mode bits per channel, on-time above
  always_comb begin
    stat = '0;
    for (int i = 0; i < 4; i++) begin
      stat[2*i +: 2] = mode_ff[i][2] ? 2'h2 : (mode_ff[i][1] ? 2'h1 : 2'h0);
    end
    stat[STAT_IDE +: TW] = ide_ff;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  auto_off_a: assert property (!ctrl_ff[CTRL_AUTO] && bnd[0] |=> mode_ff[0] == MODE_BASE)
    else $error("mode not base with auto off");
  hyst_up_a: assert property (ctrl_ff[CTRL_AUTO] && bnd[0] && mode_ff[0] == MODE_BASE
      && filter_duty[0] > lo_up_ff |=> mode_ff[0] == MODE_MID)
    else $error("no base to mid step");
  hyst_hold_a: assert property (ctrl_ff[CTRL_AUTO] && mode_ff[0] == MODE_MID
      && filter_duty[0] >= lo_lo_ff && filter_duty[0] <= hi_up_ff |=> $stable(mode_ff[0]))
    else $error("mid left inside band");
  edge_wrap_a: assert property (aedge_ff[NCH-1].a_rise == 3'h4 |-> pick[NCH-1][0] == ev[0][0])
    else $error("next channel edge not used");
  edge_set_a: assert property (pick[1][0] |=> eb_a_ff[1])
    else $error("edge-built a not set");
  pass_a: assert property (!act_ff[0].comb_en |=> pwm_out_a[0] == $past(w[0].a))
    else $error("pass-through a wrong");
  aux3_wrap_a: assert property (act_ff[NCH-1].comb_en && act_ff[NCH-1].sel_a == CMB_AUX3
      |=> pwm_out_a[NCH-1] == $past(w[(NCH+2)%NCH].aux))
    else $error("wrap aux select wrong");
  cross_b_a: assert property (act_ff[0].comb_en && act_ff[0].sel_b == CMB_CROSS
      |=> pwm_out_b[0] == $past(w[0].a))
    else $error("crossover b wrong");
  cfg_hold_a: assert property (!bnd[0] |=> $stable(act_ff[0]) && $stable(aedge_ff[0]))
    else $error("set changed mid period");
  trip_cut_a: assert property (cl_trip[0] && !act_ff[0].comb_en |=> !pwm_out_a[0])
    else $error("a not cut on trip");
  sr_hold_a: assert property (!out_nominal |=> !sr_drive[0] [*2])
    else $error("rectifier on before nominal");

  high_c: cover property (mode_ff[0] == MODE_HIGH);
  trip_c: cover property (w[0].a ##1 cl_trip[0]);
  comb_c: cover property (act_ff[0].comb_en && act_ff[0].sel_a == CMB_EDGE);

endmodule : pwmem_top
`default_nettype wire

// File: src/pwmem_pkg.sv
// package: constants, register map and carrier types of the pwm edge/mux block
package pwmem_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NCH_DEF = 4;
  localparam int TW_DEF  = 16;
  localparam int AW      = 8;
  localparam int DW      = 32;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [AW-1:0] REG_PERIOD = 8'h04;
  localparam logic [AW-1:0] REG_LO_UP  = 8'h08;
  localparam logic [AW-1:0] REG_LO_LO  = 8'h0C;
  localparam logic [AW-1:0] REG_HI_UP  = 8'h10;
  localparam logic [AW-1:0] REG_HI_LO  = 8'h14;
  localparam logic [AW-1:0] REG_CFG_B  = 8'h18;
  localparam logic [AW-1:0] REG_CFG_M  = 8'h1C;
  localparam logic [AW-1:0] REG_CFG_H  = 8'h20;
  localparam logic [AW-1:0] REG_EDGE   = 8'h24;
  localparam logic [AW-1:0] REG_BLANK  = 8'h28;
  localparam logic [AW-1:0] REG_VIN    = 8'h2C;
  localparam logic [AW-1:0] REG_VOUT   = 8'h30;
  localparam logic [AW-1:0] REG_STAT   = 8'h34;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_AUTO  = 0;
  localparam int CTRL_MATCH = 1;
  localparam int CTRL_SR    = 2;
  localparam int STAT_IDE   = 16;
  localparam int BLANK_END  = 16;

  // ****************************************
  // reset values and timing counts
  // ****************************************
  localparam logic [15:0] PERIOD_RST = 16'h0190;
  localparam logic [15:0] LO_UP_RST  = 16'h0050;
  localparam logic [15:0] LO_LO_RST  = 16'h0040;
  localparam logic [15:0] HI_UP_RST  = 16'h0100;
  localparam logic [15:0] HI_LO_RST  = 16'h00E0;
  localparam logic [15:0] VOUT_RST   = 16'h0000;
  localparam int          RAMP_PER   = 16;
  localparam int          IDE_SHIFT  = 15;

  // ****************************************
  // codes
  // ****************************************
  localparam logic [3:0] CMB_PASS  = 4'h0;
  localparam logic [3:0] CMB_EDGE  = 4'h1;
  localparam logic [3:0] CMB_AUX   = 4'h2;
  localparam logic [3:0] CMB_CROSS = 4'h3;
  localparam logic [3:0] CMB_NXT_A = 4'h4;
  localparam logic [3:0] CMB_NXT_B = 4'h5;
  localparam logic [3:0] CMB_AUX1  = 4'h6;
  localparam logic [3:0] CMB_AUX2  = 4'h7;
  localparam logic [3:0] CMB_AUX3  = 4'h8;
  localparam int         EDGE_NEXT = 2;

  typedef enum logic [2:0] {
    MODE_BASE = 3'b001,
    MODE_MID  = 3'b010,
    MODE_HIGH = 3'b100
  } pwmem_mode_t;

  // combiner config set: bit 0 enable, sel_a [4:1], sel_b [8:5]
  typedef struct packed {
    logic [3:0] sel_b;
    logic [3:0] sel_a;
    logic       comb_en;
  } pwmem_cfg_t;

  // edge sources: a_rise [2:0] .. b_fall [11:9]
  typedef struct packed {
    logic [2:0] b_fall;
    logic [2:0] b_rise;
    logic [2:0] a_fall;
    logic [2:0] a_rise;
  } pwmem_edge_t;

  typedef struct packed {
    logic aux;
    logic b;
    logic a;
  } pwmem_wave_t;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } pwmem_req_t;

endpackage : pwmem_pkg

// File: src/pwmem_chan.sv
// one pwm channel: period counter, a/b/aux windows, truncation and matching
`timescale 1ns/100ps
`default_nettype none
module pwmem_chan #(
  parameter int TW = pwmem_pkg::TW_DEF
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic [TW-1:0]     period,
  input  wire logic [TW-1:0]     duty,
  input  wire logic [TW-1:0]     blank_begin,
  input  wire logic [TW-1:0]     blank_end,
  input  wire logic              match_en,
  input  wire logic              cl_trip,
  output pwmem_pkg::pwmem_wave_t wave,
  output logic                   bnd,
  output logic [TW-1:0]          cnt
);
  import pwmem_pkg::*;

  logic [TW-1:0] cnt_ff;
  logic [TW-1:0] duty_ff;
  logic [TW-1:0] twid_ff;
  logic          trunc_ff;
  logic          a_win;
  logic [TW-1:0] half;
  logic [TW-1:0] bw;

  // ****************************************
  // period counter
  // ****************************************
  assign bnd = (cnt_ff >= period - TW'(1));
  assign cnt = cnt_ff;

  // count up, wrap at period end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= bnd ? '0 : cnt_ff + TW'(1);
    end
  end

  // duty taken once per period only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      duty_ff <= '0;
    end else if (bnd) begin
      duty_ff <= duty;
    end
  end

  // ****************************************
  // truncation of a
  // ****************************************
  assign a_win = (cnt_ff < duty_ff);

  // trip in conduction ends a and keeps its width
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trunc_ff <= 1'b0;
      twid_ff  <= '0;
    end else if (bnd) begin
      trunc_ff <= 1'b0;
    end else if (cl_trip && a_win && !trunc_ff) begin
      trunc_ff <= 1'b1;
      twid_ff  <= cnt_ff;
    end
  end

  // ****************************************
  // waveforms
  // ****************************************
  assign half  = period >> 1;
  assign bw    = (match_en && trunc_ff) ? twid_ff : duty_ff;
  assign wave.a   = a_win && !trunc_ff && !cl_trip;
  assign wave.b   = (cnt_ff >= half) && ((cnt_ff - half) < bw);
  assign wave.aux = (cnt_ff >= blank_begin) && (cnt_ff < blank_end);

endmodule : pwmem_chan
`default_nettype wire

// File: tb/pwmem_stage.sv
// partner model: loop filter duty source, output nominal flag and current comparator
`timescale 1ns/100ps
`default_nettype none
module pwmem_stage #(
  parameter int NCH = 4,
  parameter int TW  = 16
) (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire logic [NCH-1:0]         pwm_out_a,
  input  wire logic [NCH-1:0][TW-1:0] duty_set,
  input  wire logic                   nominal_set,
  input  wire logic                   trip_en,
  input  wire logic [TW-1:0]          trip_lim,
  output logic [NCH-1:0][TW-1:0]      filter_duty,
  output logic [NCH-1:0]              cl_trip,
  output logic                        out_nominal
);
  // ****************************************
  // filter output and conduction length
  // ****************************************
  logic [NCH-1:0][TW-1:0] run_ff;

  // duty and nominal flag follow the bench one cycle later
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filter_duty <= '0;
      out_nominal <= 1'b0;
      run_ff      <= '0;
    end else begin
      filter_duty <= duty_set;
      out_nominal <= nominal_set;
      for (int c = 0; c < NCH; c++) begin
        run_ff[c] <= pwm_out_a[c] ? run_ff[c] + TW'(1) : '0;
      end
    end
  end

  // ****************************************
  // comparator
  // ****************************************
  // trips once a has conducted for trip_lim cycles, drops when a ends
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      cl_trip[c] = trip_en & pwm_out_a[c] & (run_ff[c] >= trip_lim - TW'(1));
    end
  end
endmodule : pwmem_stage
`default_nettype wire

// File: tb/tb_top.sv
// testbench: registers, combiner, edge builder, truncation, mode switching, rectifier
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sn) begin check_count++; if ((sn) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s exp %0h seen %0h", nm, ex, sn); end end
module tb_top;
  import pwmem_pkg::*;
  // ****************************************
  // signals and expectations
  // ****************************************
  localparam int P = 64;
  localparam int AX = 12;
  localparam int VIN = 32'h00004000;
  localparam int VOUT = 32'h00001000;
  logic ref_clk, nrst, reg_wr, reg_rd, nominal_set, trip_en;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, rd_data;
  logic [3:0][15:0] duty_set, filter_duty;
  logic [3:0] cl_trip, pwm_out_a, pwm_out_b, sr_drive;
  logic out_nominal;
  logic [15:0] trip_lim;
  int miscompares, check_count, code, ek, lim;
  int ca[4], cb[4], cs[4], d[4];
  int codes[8] = '{0, 2, 3, 4, 5, 6, 7, 8};
  int dm[7] = '{25, 15, 5, 25, 45, 35, 25};
  int md[7] = '{1, 1, 0, 1, 2, 2, 1};
  logic [7:0] ra[7] = '{REG_PERIOD, REG_LO_UP, REG_LO_LO, REG_HI_UP, REG_HI_LO, REG_VOUT, 8'hFC};
  logic [15:0] rv[7] = '{PERIOD_RST, LO_UP_RST, LO_LO_RST, HI_UP_RST, HI_LO_RST, VOUT_RST, 16'h0};

  pwmem_top #(.NCH(4), .TW(16)) uut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .filter_duty(filter_duty), .cl_trip(cl_trip), .out_nominal(out_nominal),
    .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .sr_drive(sr_drive));
  pwmem_stage #(.NCH(4), .TW(16)) stage (.ref_clk(ref_clk), .nrst(nrst), .pwm_out_a(pwm_out_a),
    .duty_set(duty_set), .nominal_set(nominal_set), .trip_en(trip_en), .trip_lim(trip_lim),
    .filter_duty(filter_duty), .cl_trip(cl_trip), .out_nominal(out_nominal));

  // b width per period is capped at half the period
  function automatic int bw(int c);
    return (d[c] < P / 2) ? d[c] : P / 2;
  endfunction : bw
  // expected high cycles per period for a combiner code
  function automatic int wid(int cd, int c, bit isb);
    int n;
    n = (c + 1) % 4;
    case (cd)
      0: return isb ? bw(c) : d[c];
      1: return ek[0] ? bw((c + ek / 2) % 4) : d[(c + ek / 2) % 4];
      3: return isb ? d[c] : bw(c);
      4: return d[n];
      5: return bw(n);
      default: return AX;
    endcase
  endfunction : wid

  // ****************************************
  // bus, stimulus and measurement tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_data = reg_rdata;
  endtask : rd
  task automatic setd(int base, int span);
    @(posedge ref_clk);
    for (int c = 0; c < 4; c++) begin
      d[c] = base + (span > 0 ? $urandom % span : 0);
      duty_set[c] <= 16'(d[c]);
    end
  endtask : setd
  // settle three periods, then count high cycles over np periods
  task automatic meas(int np);
    repeat (3 * P) @(posedge ref_clk);
    ca = '{default: 0};
    cb = '{default: 0};
    cs = '{default: 0};
    repeat (np * P) begin
      @(negedge ref_clk);
      for (int c = 0; c < 4; c++) begin
        ca[c] += int'(pwm_out_a[c] === 1'b1);
        cb[c] += int'(pwm_out_b[c] === 1'b1);
        cs[c] += int'(sr_drive[c] === 1'b1);
      end
    end
  endtask : meas
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // clock, watchdog and test sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // about two hundred forty periods expected, 600 allowed
  initial begin
    #(600 * P * 10);
    miscompares++;
    finish_test();
  end
  initial begin
    {nrst, reg_wr, reg_rd, nominal_set, trip_en} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    duty_set = '0;
    trip_lim = 16'h0002;
    void'($urandom(26));
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i]);
      `CHK("reg_reset", 32'(rv[i]), rd_data)
    end
    $display("test reset_values done");
    wr(REG_PERIOD, 32'(P));
    wr(REG_BLANK, 32'h00140008);
    setd(33, 30);
    for (int i = 0; i < 13; i++) begin
      code = (i < 8) ? codes[i] : (i < 12 ? 1 : 3);
      ek = i - 8;
      wr(REG_EDGE, 32'({3'(2 * ek + 1), 3'(2 * ek), 3'(2 * ek + 1), 3'(2 * ek)}));
      // combiner on for all but the last setting, edge builder selected through it
      wr(REG_CFG_B, 32'({4'(code), 4'(code), i < 12}));
      meas(4);
      for (int c = 0; c < 4; c++) begin
        `CHK("comb_a", 4 * wid(i < 12 ? code : 0, c, 1'b0), ca[c])
        `CHK("comb_b", 4 * wid(i < 12 ? code : 0, c, 1'b1), cb[c])
      end
    end
    $display("test combiner done");
    wr(REG_CFG_B, 32'h0);
    setd(50, 10);
    lim = 5 + $urandom % 20;
    trip_lim <= 16'(lim);
    trip_en <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr(REG_CTRL, 32'(m * 2));
      meas(4);
      for (int c = 0; c < 4; c++) begin
        `CHK("trunc_a", 4 * lim, ca[c])
        `CHK("match_b", 4 * (m == 1 ? lim : P / 2), cb[c])
      end
    end
    trip_en <= 1'b0;
    $display("test truncation done");
    wr(REG_LO_UP, 32'h14);
    wr(REG_LO_LO, 32'h0A);
    wr(REG_HI_UP, 32'h28);
    wr(REG_HI_LO, 32'h1E);
    wr(REG_CFG_M, 32'({4'h0, CMB_AUX, 1'b1}));
    wr(REG_CFG_H, 32'({4'h0, CMB_CROSS, 1'b1}));
    wr(REG_CTRL, 32'h1);
    for (int i = 0; i < 7; i++) begin
      setd(dm[i], 0);
      meas(4);
      rd(REG_STAT);
      `CHK("mode", {4{2'(md[i])}}, rd_data[7:0])
      `CHK("mode_a", 4 * (md[i] == 0 ? d[0] : (md[i] == 1 ? AX : bw(0))), ca[0])
    end
    $display("test mode_switch done");
    wr(REG_CTRL, 32'h4);
    wr(REG_VIN, 32'(VIN));
    wr(REG_VOUT, 32'(VOUT));
    setd(40, 20);
    meas(4);
    `CHK("sr_before_nominal", 0, cs[0])
    rd(REG_STAT);
    `CHK("ide_on_time", 16'((d[0] * (VIN - VOUT)) >> 15), rd_data[31:16])
    nominal_set <= 1'b1;
    meas(4);
    `CHK("sr_ramp_start", 0, cs[0])
    repeat (60 * P) @(posedge ref_clk);
    meas(4);
    `CHK("sr_ramp_slow", 1'b1, cs[0] > 0 && cs[0] < 4 * ((d[0] * (VIN - VOUT)) >> 15))
    $display("test rectifier done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
